// ---- hdl/pbmc_top.sv ----
// Purpose: basic mode control register of an embedded 10/100 phy
// Assumes: register port from same-clock logic; negotiation and mii signals from pins
// Notes: soft reset and loopback dead time are counted in core_clk cycles
// Notes: negotiated speed and duplex come from the phy core as level pins
// Notes: the dead time is a parameter so that simulation can shorten it
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module pbmc_top #(
  parameter int DEAD_CYC = pbmc_pkg::PBMC_DEAD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic an_started,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic mii_tx_en,
  input wire logic mii_rx_dv_in,
  input wire logic [3:0] mii_rxd_in,
  input wire logic mii_col_in,
  output logic mii_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_col,
  output logic an_restart,
  output logic an_enable,
  output logic speed_100,
  output logic full_duplex,
  output logic loopback,
  output logic power_down,
  output logic isolate,
  output logic soft_reset
);
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic restart_pend_reg;
  logic [1:0] an_started_sync_reg;
  logic [1:0] an_spd_sync_reg;
  logic [1:0] an_fdx_sync_reg;
  logic [1:0] tx_en_sync_reg;
  logic [1:0] rx_dv_sync_reg;
  logic [1:0] col_sync_reg;
  logic [3:0] rxd_s1_reg;
  logic [3:0] rxd_s2_reg;
  logic srst_busy;
  logic dead_busy;
  logic srst_start;
  logic dead_start;
  logic ctrl_wr;
  logic [15:0] ctrl_view;
  logic started_now;
  logic mii_quiet;
  logic dead_gate;

  typedef enum {PBMC_RUN, PBMC_SRST} pbmc_state_t;
  pbmc_state_t state_reg;

  assign ctrl_wr = reg_wr && (reg_addr == pbmc_pkg::PBMC_OFS_CTRL);
  assign srst_start = ctrl_wr && reg_wdata[pbmc_pkg::PBMC_B_RESET] && (state_reg == PBMC_RUN);
  assign started_now = an_started_sync_reg[1];

  // pin inputs pass two flops before use; negotiation status first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      an_started_sync_reg <= 2'h0;
      an_spd_sync_reg <= 2'h0;
      an_fdx_sync_reg <= 2'h0;
    end else begin
      an_started_sync_reg <= {an_started_sync_reg[0], an_started};
      an_spd_sync_reg <= {an_spd_sync_reg[0], an_speed_100};
      an_fdx_sync_reg <= {an_fdx_sync_reg[0], an_full_duplex};
    end
  end

  // mii pins; rxd is a bus, so a nibble may tear for one cycle as it changes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_en_sync_reg <= 2'h0;
      rx_dv_sync_reg <= 2'h0;
      col_sync_reg <= 2'h0;
      rxd_s1_reg <= 4'h0;
      rxd_s2_reg <= 4'h0;
    end else begin
      tx_en_sync_reg <= {tx_en_sync_reg[0], mii_tx_en};
      rx_dv_sync_reg <= {rx_dv_sync_reg[0], mii_rx_dv_in};
      col_sync_reg <= {col_sync_reg[0], mii_col_in};
      rxd_s1_reg <= mii_rxd_in;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end

  pbmc_timer #(
    .W(8)
  ) u_srst (
    .core_clk(core_clk),
    .rst(rst),
    .start(srst_start),
    .load(8'(pbmc_pkg::PBMC_SRST_CYC)),
    .busy(srst_busy)
  );

  // soft reset sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PBMC_RUN;
    end else begin
      case (state_reg)
        PBMC_RUN: begin
          if (srst_start) begin
            state_reg <= PBMC_SRST;
          end
        end
        PBMC_SRST: begin
          if (!srst_busy) begin
            state_reg <= PBMC_RUN;
          end
        end
        default: begin
          state_reg <= PBMC_RUN;
        end
      endcase
    end
  end

  // writable bits; reserved bits never stored
  always_comb begin
    ctrl_next = ctrl_reg;
    if (state_reg == PBMC_SRST) begin
      ctrl_next = pbmc_pkg::PBMC_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_next = reg_wdata & pbmc_pkg::PBMC_CTRL_WMASK;
      if (reg_wdata[pbmc_pkg::PBMC_B_ANEN]) begin
        ctrl_next[pbmc_pkg::PBMC_B_DUPLEX] = ctrl_reg[pbmc_pkg::PBMC_B_DUPLEX];
      end
      ctrl_next[pbmc_pkg::PBMC_B_ISOL] = reg_wdata[pbmc_pkg::PBMC_B_ISOL];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= pbmc_pkg::PBMC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // restart flag: set by one written with negotiation enabled, held until negotiation starts, is disabled or soft reset runs; zero writes ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      restart_pend_reg <= 1'b0;
    end else if (state_reg == PBMC_SRST) begin
      restart_pend_reg <= 1'b0;
    end else if (ctrl_wr && reg_wdata[pbmc_pkg::PBMC_B_RESTART]
                 && ctrl_next[pbmc_pkg::PBMC_B_ANEN]) begin
      restart_pend_reg <= 1'b1;
    end else if (started_now || !ctrl_reg[pbmc_pkg::PBMC_B_ANEN]) begin
      restart_pend_reg <= 1'b0;
    end
  end
  // a written zero leaves the pending flag alone

  // loopback dead time at 100 Mbps
  assign dead_start = ctrl_next[pbmc_pkg::PBMC_B_LOOP] && !ctrl_reg[pbmc_pkg::PBMC_B_LOOP]
                      && ctrl_view[pbmc_pkg::PBMC_B_SPEED];

  pbmc_timer #(
    .W(32)
  ) u_dead (
    .core_clk(core_clk),
    .rst(rst),
    .start(dead_start),
    .load(32'(DEAD_CYC)),
    .busy(dead_busy)
  );

  // read view: with negotiation enabled, negotiated speed and duplex replace stored values
  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view[pbmc_pkg::PBMC_B_RESET] = (state_reg == PBMC_SRST);
    ctrl_view[pbmc_pkg::PBMC_B_RESTART] = restart_pend_reg;
    if (ctrl_reg[pbmc_pkg::PBMC_B_ANEN]) begin
      ctrl_view[pbmc_pkg::PBMC_B_SPEED] = an_spd_sync_reg[1];
      ctrl_view[pbmc_pkg::PBMC_B_DUPLEX] = an_fdx_sync_reg[1];
    end
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_addr == pbmc_pkg::PBMC_OFS_CTRL) begin
      reg_rdata <= ctrl_view;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // control outputs to the phy core, one flop each so they never glitch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= restart_pend_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      an_enable <= 1'b1;
    end else begin
      an_enable <= ctrl_reg[pbmc_pkg::PBMC_B_ANEN];
    end
  end

  // effective speed and duplex, so the core sees the negotiated result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      speed_100 <= 1'b1;
    end else begin
      speed_100 <= ctrl_view[pbmc_pkg::PBMC_B_SPEED];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      full_duplex <= 1'b1;
    end else begin
      full_duplex <= ctrl_view[pbmc_pkg::PBMC_B_DUPLEX];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loopback <= 1'b0;
    end else begin
      loopback <= ctrl_reg[pbmc_pkg::PBMC_B_LOOP];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= ctrl_reg[pbmc_pkg::PBMC_B_PDOWN];
    end
  end

  // isolate is passed on as stored; the host is trusted to keep it zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      isolate <= 1'b0;
    end else begin
      isolate <= ctrl_reg[pbmc_pkg::PBMC_B_ISOL];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= (state_reg == PBMC_SRST);
    end
  end

  // mii receive side: quiet in power down, rx_dv and rxd blanked during dead time
  // gate on next value too so the write cycle entering power down stays quiet
  assign mii_quiet = ctrl_next[pbmc_pkg::PBMC_B_PDOWN] || ctrl_reg[pbmc_pkg::PBMC_B_PDOWN];
  // start term covers the cycle before the timer reports busy
  assign dead_gate = dead_busy || dead_start;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mii_rx_dv <= 1'b0;
    end else if (mii_quiet) begin
      mii_rx_dv <= 1'b0;
    end else begin
      mii_rx_dv <= rx_dv_sync_reg[1] && !dead_gate;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mii_rxd <= 4'h0;
    end else if (mii_quiet) begin
      mii_rxd <= 4'h0;
    end else begin
      mii_rxd <= dead_gate ? 4'h0 : rxd_s2_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mii_col <= 1'b0;
    end else if (mii_quiet) begin
      mii_col <= 1'b0;
    end else if (ctrl_reg[pbmc_pkg::PBMC_B_COLTEST]) begin
      mii_col <= tx_en_sync_reg[1];
    end else begin
      mii_col <= col_sync_reg[1];
    end
  end
endmodule

// ---- hdl/pbmc_pkg.sv ----
// Purpose: shared constants and types for the phy basic mode control block
// Assumes: 16-bit register, 100 MHz core_clk
// Notes: bit positions and reset values of the control register
package pbmc_pkg;
  localparam logic [4:0] PBMC_OFS_CTRL = 5'h00;
  localparam logic [4:0] PBMC_OFS_STAT = 5'h01;
  localparam int PBMC_B_RESET = 15;
  localparam int PBMC_B_LOOP = 14;
  localparam int PBMC_B_SPEED = 13;
  localparam int PBMC_B_ANEN = 12;
  localparam int PBMC_B_PDOWN = 11;
  localparam int PBMC_B_ISOL = 10;
  localparam int PBMC_B_RESTART = 9;
  localparam int PBMC_B_DUPLEX = 8;
  localparam int PBMC_B_COLTEST = 7;
  localparam logic [15:0] PBMC_CTRL_RESET = 16'h3100;
  localparam logic [15:0] PBMC_CTRL_WMASK = 16'h7d80;
  localparam int PBMC_CLK_MHZ = 100;
  localparam int PBMC_SRST_NS = 640;
  localparam int PBMC_SRST_CYC = (PBMC_SRST_NS * PBMC_CLK_MHZ + 999) / 1000;
  localparam int PBMC_DEAD_MS = 720;
  localparam int PBMC_DEAD_CYC = PBMC_DEAD_MS * 1000 * PBMC_CLK_MHZ;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pbmc_req_t;

  typedef struct packed {
    logic tx_en;
    logic rx_dv;
    logic [3:0] rxd;
    logic col;
  } pbmc_mii_t;
endpackage

// ---- hdl/pbmc_timer.sv ----
// Purpose: one-shot down counter for reset and dead-time intervals
// Assumes: start is a one-cycle pulse
// Notes: restart while busy reloads the count
`timescale 1ns/1ns
module pbmc_timer #(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= load;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= start || (cnt_reg > 1);
    end
  end
endmodule

// ---- tb/pbmc_sva.sv ----
// Purpose: port checks for the control register block
// Assumes: one clock domain, async reset
// Notes: sees only top ports
`timescale 1ns/1ns
module pbmc_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] reg_rdata,
  input wire logic an_started,
  input wire logic mii_rx_dv,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_col,
  input wire logic an_restart,
  input wire logic an_enable,
  input wire logic speed_100,
  input wire logic loopback,
  input wire logic power_down,
  input wire logic soft_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  int unsigned srst_cnt;
  sequence srst_run; soft_reset [*8]; endsequence
  sequence rx_blank; !mii_rx_dv [*8]; endsequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) srst_cnt <= 0;
    else srst_cnt <= soft_reset ? srst_cnt + 1 : 0;
  end
  a_resvd_zero: assert property (reg_rdata[6:0] == 7'h0)
    else $error("reserved bits not zero");
  a_mii_quiet: assert property (power_down && $past(power_down) |->
    !mii_rx_dv && !mii_col && mii_rxd == 4'h0) else $error("mii active in power down");
  a_srst_regs: assert property (soft_reset && $past(soft_reset) |->
    an_enable && !loopback && !power_down) else $error("regs not default in soft reset");
  a_srst_len: assert property ($fell(soft_reset) |-> srst_cnt inside {[60:70]})
    else $error("soft reset length wrong");
  a_wr_srst: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[15] &&
    !soft_reset |-> ##[1:3] srst_run) else $error("soft reset not started");
  a_restart_off: assert property (!an_enable && !$past(an_enable) |-> !an_restart)
    else $error("restart pending with negotiation off");
  a_restart_hold: assert property (an_restart && an_enable && !an_started &&
    !$past(an_started) && !soft_reset && !(reg_wr && (!reg_wdata[12] || reg_wdata[15]))
    |=> an_restart) else $error("restart dropped early");
  a_loop_dead: assert property ($rose(loopback) && speed_100 |-> ##1 rx_blank)
    else $error("receive data during dead time");
endmodule
bind pbmc_top pbmc_sva u_pbmc_sva (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .an_started(an_started),
  .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_col(mii_col), .an_restart(an_restart),
  .an_enable(an_enable), .speed_100(speed_100), .loopback(loopback),
  .power_down(power_down), .soft_reset(soft_reset));

// ---- tb/pbmc_host.sv ----
// Purpose: station management master model
// Assumes: read data stand one cycle after the read strobe
// Notes: one idle cycle between requests keeps one assignment per step
`timescale 1ns/1ns
module pbmc_host (
  input wire logic core_clk,
  input wire logic [15:0] reg_rdata,
  output pbmc_pkg::pbmc_req_t req
);
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d & (d[12] ? 16'hfbff : 16'hf9ff), wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
endmodule

// ---- tb/pbmc_top_test.sv ----
// Purpose: self-checking bench for the control register block
// Assumes: dead time shortened to 50 cycles
// Notes: mii result packed as col, rx_dv, rxd
`timescale 1ns/1ns
module pbmc_top_test;
  logic core_clk, rst, an_started, an_speed_100, an_full_duplex, mii_tx_en;
  logic mii_rx_dv_in, mii_col_in, mii_rx_dv, mii_col, soft_reset;
  logic [3:0] mii_rxd_in, mii_rxd;
  logic [15:0] reg_rdata;
  logic an_restart, an_enable, speed_100, full_duplex, loopback, power_down, isolate;
  pbmc_pkg::pbmc_req_t req;
  int miscompares = 0;
  int tests_run = 0;
  pbmc_host u_pbmc_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .req(req));
  pbmc_top #(.DEAD_CYC(50)) u_pbmc_top (.core_clk(core_clk), .rst(rst), .reg_addr(req.addr),
    .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata(reg_rdata),
    .an_started(an_started), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
    .mii_tx_en(mii_tx_en), .mii_rx_dv_in(mii_rx_dv_in), .mii_rxd_in(mii_rxd_in),
    .mii_col_in(mii_col_in), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_col(mii_col),
    .an_restart(an_restart), .an_enable(an_enable), .speed_100(speed_100),
    .full_duplex(full_duplex), .loopback(loopback), .power_down(power_down),
    .isolate(isolate), .soft_reset(soft_reset));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_pbmc_host.rd(a, v);
    chk("ctrl", e, v);
  endtask
  task automatic oc(input logic [15:0] e);
    chk("ctl", e, {9'h0, an_restart, an_enable, speed_100, full_duplex, loopback,
      power_down, isolate});
  endtask
  task automatic mc(input logic [15:0] e);
    repeat (5) @(posedge core_clk);
    chk("mii", e, {10'h0, mii_col, mii_rx_dv, mii_rxd});
  endtask
  task automatic t_defaults();
    rc(5'h00, 16'h3100);
    u_pbmc_host.wr(5'h1f, 16'hffff);
    rc(5'h1f, 16'h0000);
    u_pbmc_host.wr(5'h00, 16'h317f);
    rc(5'h00, 16'h3100);
    $display("t_defaults done");
  endtask
  task automatic t_manual();
    u_pbmc_host.wr(5'h00, 16'h0200);
    rc(5'h00, 16'h0000);
    u_pbmc_host.wr(5'h00, 16'h2180);
    rc(5'h00, 16'h2180);
    oc(16'h0018);
    mii_tx_en <= 1'b1;
    mc(16'h003a);
    mii_tx_en <= 1'b0;
    mii_col_in <= 1'b1;
    mc(16'h001a);
    u_pbmc_host.wr(5'h00, 16'h2100);
    mc(16'h003a);
    mii_col_in <= 1'b0;
    $display("t_manual done");
  endtask
  task automatic t_pdown();
    u_pbmc_host.wr(5'h00, 16'h0100);
    mc(16'h001a);
    u_pbmc_host.wr(5'h00, 16'h0900);
    mii_col_in <= 1'b1;
    mc(16'h0000);
    rc(5'h00, 16'h0900);
    oc(16'h000a);
    mii_col_in <= 1'b0;
    $display("t_pdown done");
  endtask
  task automatic t_loop();
    u_pbmc_host.wr(5'h00, 16'h2100);
    mc(16'h001a);
    u_pbmc_host.wr(5'h00, 16'h6100);
    mc(16'h0000);
    repeat (60) @(posedge core_clk);
    mc(16'h001a);
    rc(5'h00, 16'h6100);
    oc(16'h001c);
    $display("t_loop done");
  endtask
  task automatic t_an();
    an_speed_100 <= 1'b0;
    an_full_duplex <= 1'b0;
    u_pbmc_host.wr(5'h00, 16'h3100);
    rc(5'h00, 16'h1000);
    u_pbmc_host.wr(5'h00, 16'h1200);
    rc(5'h00, 16'h1200);
    oc(16'h0060);
    u_pbmc_host.wr(5'h00, 16'h1000);
    rc(5'h00, 16'h1200);
    an_started <= 1'b1;
    repeat (5) @(posedge core_clk);
    rc(5'h00, 16'h1000);
    {an_started, an_speed_100, an_full_duplex} <= 3'h3;
    $display("t_an done");
  endtask
  task automatic t_srst();
    u_pbmc_host.wr(5'h00, 16'h5900);
    u_pbmc_host.wr(5'h00, 16'h8000);
    rc(5'h00, 16'hb100);
    u_pbmc_host.wr(5'h00, 16'h0000);
    rc(5'h00, 16'hb100);
    for (int i = 0; i < 200 && soft_reset !== 1'b0; i++) @(posedge core_clk);
    if (soft_reset !== 1'b0) begin
      miscompares++;
      $display("BAD soft_reset exp 0 got %b", soft_reset);
    end
    rc(5'h00, 16'h3100);
    oc(16'h0038);
    $display("t_srst done");
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {an_started, mii_tx_en, mii_col_in} = 3'h0;
    {an_speed_100, an_full_duplex, mii_rx_dv_in} = 3'h7;
    mii_rxd_in = 4'ha;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    // negotiation pins need two edges through the synchronisers
    repeat (3) @(posedge core_clk);
    t_defaults();
    t_manual();
    t_pdown();
    t_loop();
    t_an();
    t_srst();
    summarize();
  end
endmodule
